//--- hdl/pms_supervisor.sv
// Mode and protection supervisor of a boost PFC controller.
`timescale 1ns/1ps
// Operation
// - Low feedback enters idle, amplifier off, filter floats
// - Idle exit resumes without soft-start
// - Idle comparator is debounced first
// - Weak feedback pull-up while idle flag set
// - Strong pull-up until feedback reaches reference
// - Idle near turn-off enables startup source
// - Low filter pin disables, weak pull-up on
// - Enable threshold recharges supply, then soft-starts
// - Disabled: startup source cycles supply window
// - First turn-on needs line arrival
// - Later line arrival recharges supply
// - Short arrival debounce first, long after
// - Sustained line dropout stops switching
// - Overvoltage halts until release comparator
// - Overvoltage recharges supply below recharge level
// - Cycle current limit ends on-time at once
// - Two saturation cycles stop until zero current
// - Low feedback at turn-on means divider failure
// - Sense failure latches until supply recycles
// - Line level selects one of two gains
// - Soft-start ramps current limit reference
// - Supply turn-off shuts down, recharges, soft-starts
module pms_supervisor import pms_pkg::*; #(
    parameter int IDLE_DB = IDLE_DB_CYC,
    parameter int DISABLE_DB = DISABLE_DB_CYC,
    parameter int ARRIVAL_FIRST = ARRIVAL_FIRST_CYC,
    parameter int ARRIVAL_LATER = ARRIVAL_LATER_CYC,
    parameter int DROPOUT_FILT = DROPOUT_CYC,
    parameter int OVERVOLTAGE_DB = OVERVOLTAGE_DB_CYC,
    parameter int SENSE_FAIL_DB = SENSE_FAIL_DB_CYC,
    parameter int SOFT_START = SOFT_START_CYC,
    parameter int LEVEL_W = SS_LEVEL_W
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic fb_below_idle_i,
    input wire logic fb_above_idle_hyst_i,
    input wire logic fb_at_reference_i,
    input wire logic fb_overvoltage_set_i,
    input wire logic fb_overvoltage_release_i,
    input wire logic filter_below_disable_i,
    input wire logic filter_above_enable_i,
    input wire logic supply_turn_on_i,
    input wire logic supply_turn_off_i,
    input wire logic supply_near_off_i,
    input wire logic supply_below_recharge_i,
    input wire logic line_arrival_i,
    input wire logic line_dropout_i,
    input wire logic line_high_gain_sel_i,
    input wire logic cs_limit_i,
    input wire logic cs_saturation_i,
    input wire logic cs_zero_current_i,
    input wire logic cs_sense_failure_i,
    input wire logic gate_on_i,
    output logic switch_enable_o,
    output logic on_time_end_o,
    output logic low_power_o,
    output logic error_amp_enable_o,
    output logic filter_high_z_o,
    output logic filter_pullup_enable_o,
    output logic fb_weak_pullup_o,
    output logic fb_strong_pullup_o,
    output logic startup_source_enable_o,
    output logic idle_state_flag_o,
    output logic gain_select_o,
    output logic [LEVEL_W-1:0] current_limit_ref_o,
    output logic soft_start_active_o
);
    localparam int NIN = 18;
    // The turn-on check waits out the slower of its two input filters.
    localparam int CHECK_WAIT =
        (SENSE_FAIL_DB > IDLE_DB ? SENSE_FAIL_DB : IDLE_DB) + 2;
    logic [CNT_W-1:0] check_cnt;
    logic check_done;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] syn;
    logic [NIN-1:0] deb;
    logic [CNT_W-1:0] len [NIN];
    logic arrival_first;
    logic [CNT_W-1:0] arrival_len;
    pms_state_t state;
    pms_state_t next_state;
    logic idle;
    logic disabled;
    logic dropout;
    logic overvoltage;
    logic saturation;
    logic sense_fail;
    logic divider_fail;
    logic sat_prev_cycle;
    logic sat_this_cycle;
    logic gate_d;
    logic strong_pull;
    logic need_soft;
    logic [CNT_W-1:0] drop_cnt;
    logic ss_restart;
    logic ss_bypass;
    logic ss_done;
    logic stop_any;

    assign raw = {fb_at_reference_i, fb_above_idle_hyst_i,
        cs_zero_current_i, cs_saturation_i, cs_limit_i,
        line_high_gain_sel_i, line_dropout_i, line_arrival_i,
        supply_below_recharge_i, supply_near_off_i, supply_turn_off_i,
        supply_turn_on_i, filter_above_enable_i, filter_below_disable_i,
        fb_overvoltage_set_i, fb_overvoltage_release_i, cs_sense_failure_i,
        fb_below_idle_i};
    assign arrival_len = arrival_first ? CNT_W'(ARRIVAL_FIRST) :
        CNT_W'(ARRIVAL_LATER);

    // Only the idle, sense-failure, overvoltage, disable and line-arrival comparators get a debounce length of their own.
    always_comb begin
        for (int k = 0; k < NIN; k++) begin
            len[k] = CNT_W'(1);
        end
        len[0] = CNT_W'(IDLE_DB);
        len[1] = CNT_W'(SENSE_FAIL_DB);
        len[3] = CNT_W'(OVERVOLTAGE_DB);
        len[4] = CNT_W'(DISABLE_DB);
        len[10] = arrival_len;
    end

    genvar g;
    generate
        for (g = 0; g < NIN; g++) begin : g_in
            pms_debounce #(.CNT_W_P(CNT_W)) u_db (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .raw_i(raw[g]),
                .len_i(len[g]),
                .sync_o(syn[g]),
                .level_o(deb[g])
            );
        end
    endgenerate

    // Brownout is filtered by its own long counter on the synced level.
    // A brownout holds until the long-filtered line arrival is seen again.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            drop_cnt <= '0;
            dropout <= 1'b0;
        end else if (syn[11] && state == PMS_RUN) begin
            if (drop_cnt + 1'b1 >= CNT_W'(DROPOUT_FILT)) begin
                dropout <= 1'b1;
            end else begin
                drop_cnt <= drop_cnt + 1'b1;
            end
        end else begin
            drop_cnt <= '0;
            if (deb[10]) begin
                dropout <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || state != PMS_CHECK) begin
            check_cnt <= '0;
        end else if (!check_done) begin
            check_cnt <= check_cnt + 1'b1;
        end
    end

    assign check_done = (check_cnt >= CNT_W'(CHECK_WAIT));

    // Supply state machine: off, check at turn-on, run, recharge, latched stop.
    always_comb begin
        next_state = state;
        unique case (state)
            PMS_OFF: begin
                if (deb[6]) begin
                    next_state = PMS_CHECK;
                end
            end
            PMS_CHECK: begin
                if (deb[1]) begin
                    next_state = PMS_LATCHED;
                end else if (check_done && deb[6] && deb[10]) begin
                    next_state = PMS_RUN;
                end
            end
            PMS_RUN: begin
                if (deb[7]) begin
                    next_state = PMS_RECHARGE;
                end
            end
            PMS_RECHARGE: begin
                if (deb[6]) begin
                    next_state = PMS_CHECK;
                end
            end
            PMS_LATCHED: begin
                if (deb[7]) begin
                    next_state = PMS_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= PMS_OFF;
        end else begin
            state <= next_state;
        end
    end

    // First-startup arrival uses the short filter; later arrivals the long.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            arrival_first <= 1'b1;
        end else if (state == PMS_RUN) begin
            arrival_first <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            divider_fail <= 1'b0;
        end else if (state == PMS_CHECK && deb[6]) begin
            divider_fail <= deb[0];
        end else if (state != PMS_RUN && state != PMS_CHECK) begin
            divider_fail <= 1'b0;
        end else if (!deb[0]) begin
            divider_fail <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            idle <= 1'b0;
        end else if (deb[0]) begin
            idle <= 1'b1;
        end else if (syn[16] && idle) begin
            idle <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            strong_pull <= 1'b0;
        end else if (idle && syn[16]) begin
            strong_pull <= 1'b1;
        end else if (syn[17] || deb[0]) begin
            strong_pull <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            disabled <= 1'b0;
        end else if (deb[4]) begin
            disabled <= 1'b1;
        end else if (deb[5] && deb[6]) begin
            disabled <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            overvoltage <= 1'b0;
        end else if (deb[3]) begin
            overvoltage <= 1'b1;
        end else if (syn[2]) begin
            overvoltage <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sense_fail <= 1'b0;
        end else begin
            sense_fail <= (next_state == PMS_LATCHED);
        end
    end

    // Saturation is counted per switching cycle, closed at gate falling edge.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gate_d <= 1'b0;
            sat_this_cycle <= 1'b0;
            sat_prev_cycle <= 1'b0;
            saturation <= 1'b0;
        end else begin
            gate_d <= gate_on_i;
            // Clearing comes first so that a new trip in the same cycle wins.
            if (saturation && syn[15]) begin
                saturation <= 1'b0;
                sat_prev_cycle <= 1'b0;
            end
            if (gate_d && !gate_on_i) begin
                sat_prev_cycle <= sat_this_cycle;
                sat_this_cycle <= 1'b0;
                if (sat_this_cycle && sat_prev_cycle) begin
                    saturation <= 1'b1;
                end
            end else if (gate_on_i && syn[14]) begin
                sat_this_cycle <= 1'b1;
            end
        end
    end

    assign stop_any = idle || disabled || dropout || overvoltage ||
        saturation || divider_fail || sense_fail ||
        state != PMS_RUN;

    // Any cleared cause other than idle asks for a soft-start.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            need_soft <= 1'b1;
        end else if (disabled || dropout || overvoltage || saturation ||
                divider_fail || sense_fail || state != PMS_RUN) begin
            need_soft <= 1'b1;
        end else if (!stop_any) begin
            need_soft <= 1'b0;
        end
    end

    assign ss_restart = stop_any && need_soft;
    assign ss_bypass = 1'b0;

    pms_soft_start #(.RAMP_CYC(SOFT_START), .LEVEL_W(LEVEL_W)) u_ss (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .restart_i(ss_restart),
        .bypass_i(ss_bypass),
        .level_o(current_limit_ref_o),
        .done_o(ss_done)
    );

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            switch_enable_o <= 1'b0;
            low_power_o <= 1'b1;
            error_amp_enable_o <= 1'b0;
            filter_high_z_o <= 1'b0;
            filter_pullup_enable_o <= 1'b0;
            fb_weak_pullup_o <= 1'b0;
            fb_strong_pullup_o <= 1'b0;
            startup_source_enable_o <= 1'b0;
            gain_select_o <= 1'b0;
        end else begin
            switch_enable_o <= !stop_any;
            low_power_o <= idle || disabled || divider_fail || sense_fail;
            error_amp_enable_o <= !(idle || disabled);
            filter_high_z_o <= idle;
            filter_pullup_enable_o <= disabled;
            fb_weak_pullup_o <= idle && !strong_pull;
            fb_strong_pullup_o <= strong_pull;
            gain_select_o <= syn[12];
            // Once on, the source runs until the supply reaches turn-on.
            if (deb[6]) begin
                startup_source_enable_o <= 1'b0;
            end else if ((idle && syn[8]) || (disabled && deb[7]) ||
                    (disabled && deb[5]) || (overvoltage && syn[9]) ||
                    (dropout && deb[10]) ||
                    state == PMS_OFF || state == PMS_RECHARGE ||
                    (state == PMS_CHECK && deb[10] && !arrival_first)) begin
                startup_source_enable_o <= 1'b1;
            end
        end
    end

    assign idle_state_flag_o = idle;
    assign on_time_end_o = gate_on_i && (syn[13] || syn[14]);
    assign soft_start_active_o = !ss_done;
endmodule : pms_supervisor

//--- pkg/pms_pkg.sv
// Package of timing constants and state codes for the PFC supervisor.
package pms_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_NS = 25;
    // Debounce and filter times in their printed units.
    localparam int IDLE_DEBOUNCE_NS = 1800;
    localparam int DISABLE_DEBOUNCE_US = 50;
    localparam int ARRIVAL_FIRST_MS = 1;
    localparam int ARRIVAL_LATER_MS = 40;
    localparam int DROPOUT_FILTER_MS = 630;
    localparam int OVERVOLTAGE_DEBOUNCE_US = 50;
    localparam int SENSE_FAIL_DEBOUNCE_US = 10;
    localparam int SOFT_START_MS = 130;
    // Cycle counts; least times round up.
    localparam int IDLE_DB_CYC = (IDLE_DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
    localparam int DISABLE_DB_CYC = DISABLE_DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int ARRIVAL_FIRST_CYC = ARRIVAL_FIRST_MS * (CLK_HZ / 1000);
    localparam int ARRIVAL_LATER_CYC = ARRIVAL_LATER_MS * (CLK_HZ / 1000);
    localparam int DROPOUT_CYC = DROPOUT_FILTER_MS * (CLK_HZ / 1000);
    localparam int OVERVOLTAGE_DB_CYC =
        OVERVOLTAGE_DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int SENSE_FAIL_DB_CYC =
        SENSE_FAIL_DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int SOFT_START_CYC = SOFT_START_MS * (CLK_HZ / 1000);
    localparam int SS_LEVEL_W = 8;
    localparam int CNT_W = 32;

    typedef enum logic [2:0] {
        PMS_OFF = 3'b000,
        PMS_CHECK = 3'b001,
        PMS_RUN = 3'b010,
        PMS_LATCHED = 3'b011,
        PMS_RECHARGE = 3'b100
    } pms_state_t;
endpackage : pms_pkg

//--- hdl/pms_debounce.sv
// Two-stage synchroniser followed by a settling counter for one comparator.
`timescale 1ns/1ps
module pms_debounce import pms_pkg::*; #(
    parameter int CNT_W_P = CNT_W
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic raw_i,
    input wire logic [CNT_W_P-1:0] len_i,
    output logic sync_o,
    output logic level_o
);
    logic meta;
    logic sync;
    logic [CNT_W_P-1:0] count;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
        end else begin
            meta <= raw_i;
            sync <= meta;
        end
    end

    // Output follows the input only after it has held a new value long enough.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count <= '0;
            level_o <= 1'b0;
        end else if (sync == level_o) begin
            count <= '0;
        end else if (count + 1'b1 >= len_i) begin
            count <= '0;
            level_o <= sync;
        end else begin
            count <= count + 1'b1;
        end
    end

    assign sync_o = sync;
endmodule : pms_debounce

//--- hdl/pms_soft_start.sv
// Soft-start ramp of the cycle current limit reference.
`timescale 1ns/1ps
module pms_soft_start import pms_pkg::*; #(
    parameter int RAMP_CYC = SOFT_START_CYC,
    parameter int LEVEL_W = SS_LEVEL_W
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic restart_i,
    input wire logic bypass_i,
    output logic [LEVEL_W-1:0] level_o,
    output logic done_o
);
    localparam int STEP_CYC = (RAMP_CYC >> LEVEL_W) > 0 ?
        (RAMP_CYC >> LEVEL_W) : 1;
    logic [CNT_W-1:0] tick;

    // The ramp advances one level step per divider tick.
    always_ff @(posedge clk_i) begin
        if (srst_i || restart_i) begin
            tick <= '0;
            level_o <= '0;
        end else if (bypass_i) begin
            tick <= '0;
            level_o <= '1;
        end else if (level_o != '1) begin
            if (tick >= CNT_W'(STEP_CYC - 1)) begin
                tick <= '0;
                level_o <= level_o + 1'b1;
            end else begin
                tick <= tick + 1'b1;
            end
        end
    end

    assign done_o = (level_o == '1);
endmodule : pms_soft_start

//--- sim/pms_supervisor_chk.sv
// Port-level assertion checker for the supervisor.
`timescale 1ns/1ps
module pms_supervisor_chk import pms_pkg::*; #(
    parameter int LEVEL_W = SS_LEVEL_W
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic fb_below_idle_i,
    input wire logic supply_near_off_i,
    input wire logic cs_limit_i,
    input wire logic cs_saturation_i,
    input wire logic gate_on_i,
    input wire logic switch_enable_o,
    input wire logic on_time_end_o,
    input wire logic low_power_o,
    input wire logic error_amp_enable_o,
    input wire logic filter_high_z_o,
    input wire logic filter_pullup_enable_o,
    input wire logic fb_weak_pullup_o,
    input wire logic fb_strong_pullup_o,
    input wire logic startup_source_enable_o,
    input wire logic idle_state_flag_o,
    input wire logic [LEVEL_W-1:0] current_limit_ref_o
);
    property p_reset_state;
        @(posedge clk_i) srst_i |=> !switch_enable_o && low_power_o
            && current_limit_ref_o == '0;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset state wrong");
    // Idle outputs may trail the flag by one edge, so settle first.
    property p_idle_stop;
        @(posedge clk_i) disable iff (srst_i)
        idle_state_flag_o && $past(idle_state_flag_o) |->
            !switch_enable_o && !error_amp_enable_o && filter_high_z_o;
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("idle outputs wrong");
    property p_idle_pull;
        @(posedge clk_i) disable iff (srst_i)
        idle_state_flag_o && $past(idle_state_flag_o) |->
            fb_weak_pullup_o != fb_strong_pullup_o;
    endproperty
    a_idle_pull: assert property (p_idle_pull)
        else $error("weak pull-up missing");
    property p_idle_filter;
        @(posedge clk_i) disable iff (srst_i) $rose(idle_state_flag_o) |->
            $past(fb_below_idle_i, 3) && $past(fb_below_idle_i, 5);
    endproperty
    a_idle_filter: assert property (p_idle_filter)
        else $error("idle entered without settling");
    property p_idle_supply;
        @(posedge clk_i) disable iff (srst_i)
        idle_state_flag_o && supply_near_off_i |->
            ##[1:4] startup_source_enable_o;
    endproperty
    a_idle_supply: assert property (p_idle_supply)
        else $error("startup source not enabled");
    property p_limit_end;
        @(posedge clk_i) disable iff (srst_i) on_time_end_o == (gate_on_i
            && ($past(cs_limit_i, 2) || $past(cs_saturation_i, 2)));
    endproperty
    a_limit_end: assert property (p_limit_end)
        else $error("on-time end wrong");
    property p_disable_stop;
        @(posedge clk_i) disable iff (srst_i)
        filter_pullup_enable_o && $past(filter_pullup_enable_o) |->
            !switch_enable_o && !error_amp_enable_o;
    endproperty
    a_disable_stop: assert property (p_disable_stop)
        else $error("disable outputs wrong");
    property p_ramp_step;
        @(posedge clk_i) disable iff (srst_i)
        current_limit_ref_o != $past(current_limit_ref_o) |->
            current_limit_ref_o == $past(current_limit_ref_o) + 1'b1
            || current_limit_ref_o == '0;
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("ramp jumped");
endmodule : pms_supervisor_chk

bind pms_supervisor pms_supervisor_chk #(.LEVEL_W(LEVEL_W)) u_chk (.*);

//--- sim/pms_gate_model.sv
// Behavioural gate-drive stage facing the supervisor.
`timescale 1ns/1ps
module pms_gate_model #(
    parameter int ON_CYC = 8,
    parameter int PERIOD_CYC = 14
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic switch_enable_i,
    input wire logic on_time_end_i,
    output logic gate_on_o
);
    int cnt;
    logic cut;
    // A cut-off holds the gate low for the rest of the period.
    always_ff @(posedge clk_i) begin
        if (srst_i || !switch_enable_i) begin
            cnt <= 0;
            cut <= 1'b0;
            gate_on_o <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD_CYC - 1) ? 0 : cnt + 1;
            cut <= (cnt == PERIOD_CYC - 1) ? 1'b0 : (cut | on_time_end_i);
            gate_on_o <= (cnt < ON_CYC) && !on_time_end_i && !cut;
        end
    end
endmodule : pms_gate_model

//--- sim/tb_top.sv
// Self-checking bench for the PFC mode and protection supervisor.
`timescale 1ns/1ps
module tb_top;
    import pms_pkg::*;
    localparam int ARR1 = 40;
    localparam int ARR2 = 80;
    localparam int DROP = 100;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic fb_below_idle_i, fb_above_idle_hyst_i, fb_at_reference_i;
    logic fb_overvoltage_set_i, fb_overvoltage_release_i;
    logic filter_below_disable_i, filter_above_enable_i;
    logic supply_turn_on_i, supply_turn_off_i, supply_near_off_i;
    logic supply_below_recharge_i, line_arrival_i, line_dropout_i;
    logic line_high_gain_sel_i, cs_limit_i, cs_saturation_i;
    logic cs_zero_current_i, cs_sense_failure_i, gate_on_i;
    logic switch_enable_o, on_time_end_o, low_power_o, error_amp_enable_o;
    logic filter_high_z_o, filter_pullup_enable_o, fb_weak_pullup_o;
    logic fb_strong_pullup_o, startup_source_enable_o, idle_state_flag_o;
    logic gain_select_o, soft_start_active_o;
    logic [SS_LEVEL_W-1:0] current_limit_ref_o;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;

    always #12.5 clk_i = ~clk_i;

    pms_supervisor #(.IDLE_DB(4), .DISABLE_DB(8), .ARRIVAL_FIRST(ARR1),
        .ARRIVAL_LATER(ARR2), .DROPOUT_FILT(DROP), .OVERVOLTAGE_DB(8),
        .SENSE_FAIL_DB(6), .SOFT_START(1024)) uut (.*);
    pms_gate_model u_gate (.clk_i(clk_i), .srst_i(srst_i),
        .switch_enable_i(switch_enable_o), .on_time_end_i(on_time_end_o),
        .gate_on_o(gate_on_i));

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : step
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_sw(input logic lvl, input int lim);
        for (int n = 0; n < lim && switch_enable_o !== lvl; n++) step(1);
    endtask : wait_sw
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    // The ceiling is several times the length of the whole sequence.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        {fb_below_idle_i, fb_overvoltage_set_i, fb_overvoltage_release_i,
         filter_below_disable_i, filter_above_enable_i, supply_turn_on_i,
         supply_turn_off_i, supply_near_off_i, supply_below_recharge_i,
         line_arrival_i, line_dropout_i, line_high_gain_sel_i, cs_limit_i,
         cs_saturation_i, cs_zero_current_i, cs_sense_failure_i} = '0;
        fb_above_idle_hyst_i = 1'b1;
        fb_at_reference_i = 1'b1;
        step(3);
        srst_i = 1'b0;
        chk(low_power_o, 1'b1);
        supply_turn_on_i = 1'b1;
        step(2 * ARR1);
        chk(switch_enable_o, 1'b0);
        line_arrival_i = 1'b1;
        step(ARR1 - 4);
        chk(switch_enable_o, 1'b0);
        wait_sw(1'b1, 20);
        chk(switch_enable_o, 1'b1);
        chk(soft_start_active_o, 1'b1);
        line_high_gain_sel_i = 1'b1;
        step(4);
        chk(gain_select_o, 1'b1);
        line_high_gain_sel_i = 1'b0;
        step(4);
        chk(gain_select_o, 1'b0);
        for (int n = 0; n < 1100 && soft_start_active_o !== 1'b0; n++) step(1);
        chk(current_limit_ref_o, 8'hff);
        $display("test startup done");
        fb_below_idle_i = 1'b1;
        fb_above_idle_hyst_i = 1'b0;
        fb_at_reference_i = 1'b0;
        step(4);
        chk(idle_state_flag_o, 1'b0);
        step(6);
        chk(idle_state_flag_o, 1'b1);
        chk(switch_enable_o, 1'b0);
        chk(fb_weak_pullup_o, 1'b1);
        supply_turn_on_i = 1'b0;
        supply_near_off_i = 1'b1;
        step(4);
        chk(startup_source_enable_o, 1'b1);
        supply_near_off_i = 1'b0;
        supply_turn_on_i = 1'b1;
        fb_below_idle_i = 1'b0;
        fb_above_idle_hyst_i = 1'b1;
        wait_sw(1'b1, 10);
        chk(switch_enable_o, 1'b1);
        chk(fb_strong_pullup_o, 1'b1);
        chk(soft_start_active_o, 1'b0);
        fb_at_reference_i = 1'b1;
        step(4);
        chk(fb_strong_pullup_o, 1'b0);
        $display("test idle done");
        for (int n = 0; n < 30 && gate_on_i !== 1'b1; n++) step(1);
        cs_limit_i = 1'b1;
        step(4);
        cs_limit_i = 1'b0;
        chk(switch_enable_o, 1'b1);
        cs_saturation_i = 1'b1;
        wait_sw(1'b0, 60);
        chk(switch_enable_o, 1'b0);
        cs_saturation_i = 1'b0;
        step(20);
        chk(switch_enable_o, 1'b0);
        cs_zero_current_i = 1'b1;
        wait_sw(1'b1, 20);
        chk(switch_enable_o, 1'b1);
        cs_zero_current_i = 1'b0;
        $display("test current done");
        fb_overvoltage_set_i = 1'b1;
        step(6);
        chk(switch_enable_o, 1'b1);
        wait_sw(1'b0, 10);
        chk(switch_enable_o, 1'b0);
        supply_turn_on_i = 1'b0;
        supply_below_recharge_i = 1'b1;
        step(4);
        chk(startup_source_enable_o, 1'b1);
        supply_below_recharge_i = 1'b0;
        supply_turn_on_i = 1'b1;
        fb_overvoltage_set_i = 1'b0;
        step(10);
        chk(switch_enable_o, 1'b0);
        fb_overvoltage_release_i = 1'b1;
        wait_sw(1'b1, 20);
        chk(switch_enable_o, 1'b1);
        fb_overvoltage_release_i = 1'b0;
        $display("test overvoltage done");
        filter_below_disable_i = 1'b1;
        step(14);
        chk(filter_pullup_enable_o, 1'b1);
        chk(error_amp_enable_o, 1'b0);
        filter_below_disable_i = 1'b0;
        supply_turn_on_i = 1'b0;
        filter_above_enable_i = 1'b1;
        step(6);
        chk(startup_source_enable_o, 1'b1);
        supply_turn_on_i = 1'b1;
        wait_sw(1'b1, ARR2 + 20);
        chk(switch_enable_o, 1'b1);
        chk(soft_start_active_o, 1'b1);
        filter_above_enable_i = 1'b0;
        $display("test disable done");
        line_arrival_i = 1'b0;
        line_dropout_i = 1'b1;
        step(DROP - 10);
        chk(switch_enable_o, 1'b1);
        wait_sw(1'b0, 20);
        chk(switch_enable_o, 1'b0);
        line_dropout_i = 1'b0;
        line_arrival_i = 1'b1;
        step(ARR1 + 10);
        chk(switch_enable_o, 1'b0);
        wait_sw(1'b1, ARR2);
        chk(switch_enable_o, 1'b1);
        $display("test line done");
        supply_turn_on_i = 1'b0;
        supply_turn_off_i = 1'b1;
        step(5);
        chk(switch_enable_o, 1'b0);
        chk(startup_source_enable_o, 1'b1);
        cs_sense_failure_i = 1'b1;
        supply_turn_off_i = 1'b0;
        supply_turn_on_i = 1'b1;
        step(ARR2 + 40);
        cs_sense_failure_i = 1'b0;
        step(ARR2);
        chk(switch_enable_o, 1'b0);
        supply_turn_on_i = 1'b0;
        supply_turn_off_i = 1'b1;
        step(4);
        supply_turn_off_i = 1'b0;
        supply_turn_on_i = 1'b1;
        wait_sw(1'b1, ARR2 + 40);
        chk(switch_enable_o, 1'b1);
        $display("test sense done");
        print_verdict();
    end
endmodule : tb_top
